// file: hdl/meas_pkg.sv
// Shared constants and types of the sensor measurement control block.
package meas_pkg;

  localparam logic [7:0] STATUS_CTRL_ADDR = 8'h00;
  localparam logic [7:0] MODE_CTRL_ADDR   = 8'h04;

  localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_CTRL_RESET   = 8'h00;

  localparam int ACQ_EN_POS    = 4;
  localparam int LP_DIRECT_POS = 3;
  localparam int DIRECT_EN_POS = 7;
  localparam int CAPTURE_POS   = 6;
  localparam int CHAN_HI_POS   = 5;
  localparam int CHAN_LO_POS   = 4;
  localparam int PARITY_POS    = 3;

  localparam logic [7:0] AUTO_SETTLE_CYCLES = 8'h20;
  localparam logic [7:0] LP_PERIOD_CYCLES   = 8'h40;
  localparam logic [7:0] CNT_STEP           = 8'h01;
  localparam logic [7:0] CNT_ZERO           = 8'h00;

  typedef enum logic [1:0] {
    CHAN_PRESSURE = 2'h0,
    CHAN_ACCEL1   = 2'h1,
    CHAN_ACCEL0   = 2'h2,
    CHAN_AUX      = 2'h3
  } chan_t;

  typedef enum logic [2:0] {
    AUTO_IDLE   = 3'h1,
    AUTO_SETTLE = 3'h2,
    AUTO_CONV   = 3'h4
  } auto_state_t;

  typedef enum logic [2:0] {
    LP_IDLE = 3'h1,
    LP_WAIT = 3'h2,
    LP_CONV = 3'h4
  } lp_state_t;

endpackage : meas_pkg

// file: hdl/lp_trigger_fsm.sv
// Autonomous converter trigger pacing for the low-power direct mode.
module lp_trigger_fsm
  import meas_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic adc_done,
  output logic      trig
);

  lp_state_t  state_q;
  lp_state_t  state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       trig_d;

  wire period_end = (cnt_q == LP_PERIOD_CYCLES - CNT_STEP);

  // Each period ends in one trigger, then the machine waits for the conversion.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    trig_d  = 1'b0;
    case (state_q)
      LP_IDLE: begin
        cnt_d = CNT_ZERO;
        if (run) begin
          state_d = LP_WAIT;
        end
      end
      LP_WAIT: begin
        cnt_d = cnt_q + CNT_STEP;
        if (!run) begin
          state_d = LP_IDLE;
        end else if (period_end) begin
          state_d = LP_CONV;
          trig_d  = 1'b1;
        end
      end
      LP_CONV: begin
        cnt_d = CNT_ZERO;
        if (!run) begin
          state_d = LP_IDLE;
        end else if (adc_done) begin
          state_d = LP_WAIT;
        end
      end
      default: begin
        state_d = LP_IDLE;
        cnt_d   = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LP_IDLE;
      cnt_q   <= CNT_ZERO;
      trig    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trig    <= trig_d;
    end
  end

endmodule // lp_trigger_fsm

// file: hdl/sensor_meas_control.sv
// Measurement control of the sensor interface with its APB register slave.

// How it works
// - Acquisition enable written 1 while idle powers the converter and starts a cycle.
// - Acquisition enable reads 1 during a measurement, 0 when complete or idle.
// - Low-power bit picks full-power direct mode or hardware-paced low-power mode.
// - Direct enable cannot be set during automatic acquisition, or while the low-power bit is set outside its entry window.
// - Setting direct enable starts measuring with no settling delay and no trigger.
// - Capture clears itself when the low-power bit falls.
// - Capture writes are ignored while automatic acquisition runs.
// - In direct mode capture written 1 triggers one conversion, then self-clears.
// - In low-power mode capture stays 1 while hardware issues triggers.
// - Channel field steers the multiplexer: pressure, accel 1, accel 0, auxiliary.
// - Parity fault flag reads 1 after a detected parity error, 0 after reset.
// - Mode control register resets to all zeros.
module sensor_meas_control
  import meas_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             c2v_power,
  output logic      [1:0]  chan_select,
  output logic             adc_trigger,
  input  wire logic        adc_done,
  input  wire logic        parity_error
);

  // One bit of a written byte, picked by its field position.
  function automatic logic field_bit(
    input logic [7:0] data,
    input int         pos
  );
    field_bit = data[pos];
  endfunction

  // A flag that hardware or a write sets and an event clears; the set wins a tie.
  function automatic logic set_clear(
    input logic set,
    input logic clr,
    input logic q
  );
    set_clear = set ? 1'b1 : (clr ? 1'b0 : q);
  endfunction

  // True when the bus address selects the register at the given offset.
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  // Status byte as software reads it; every other position reads 0.
  function automatic logic [7:0] pack_status(
    input logic acq,
    input logic low_power
  );
    logic [7:0] b;
    b                = 8'h00;
    b[ACQ_EN_POS]    = acq;
    b[LP_DIRECT_POS] = low_power;
    pack_status      = b;
  endfunction

  // Mode byte as software reads it; the reserved low bits read 0.
  function automatic logic [7:0] pack_mode(
    input logic       direct,
    input logic       capture,
    input logic [1:0] chan,
    input logic       parity
  );
    logic [7:0] b;
    b                          = 8'h00;
    b[DIRECT_EN_POS]           = direct;
    b[CAPTURE_POS]             = capture;
    b[CHAN_HI_POS:CHAN_LO_POS] = chan;
    b[PARITY_POS]              = parity;
    pack_mode                  = b;
  endfunction

  // Read data of the selected register; an unmapped address reads 0.
  function automatic logic [7:0] read_select(
    input logic       sel_status,
    input logic       sel_mode,
    input logic [7:0] status_byte,
    input logic [7:0] mode_byte
  );
    read_select = 8'h00;
    if (sel_status) begin
      read_select = status_byte;
    end else if (sel_mode) begin
      read_select = mode_byte;
    end
  endfunction

  logic        sen_q;
  logic        sen_d;
  logic        low_power_direct_bit_q;
  logic        low_power_direct_bit_d;
  logic        direct_q;
  logic        direct_d;
  logic        capture_q;
  logic        capture_d;
  logic [1:0]  chan_q;
  logic [1:0]  chan_d;
  logic        parity_q;
  logic        parity_d;
  logic        lp_entry_q;
  logic        lp_entry_d;
  logic        c2v_q;
  logic        trig_q;
  logic        trig_d;
  logic [31:0] prdata_q;
  auto_state_t auto_q;
  auto_state_t auto_d;
  logic [7:0]  settle_q;
  logic [7:0]  settle_d;
  logic        auto_trig;
  logic        lp_trig;

  // Bus decode.
  wire         setup_phase  = psel & ~penable;
  wire         access_phase = psel & penable;
  wire         hit_status   = addr_hit(paddr, STATUS_CTRL_ADDR);
  wire         hit_mode     = addr_hit(paddr, MODE_CTRL_ADDR);
  wire         mapped       = hit_status | hit_mode;
  wire         wr_en        = access_phase & pwrite & pstrb[0] & mapped;
  wire         wr_status    = wr_en & hit_status;
  wire         wr_mode      = wr_en & hit_mode;
  wire [7:0]   wdat         = pwdata[7:0];

  wire         w_sen        = field_bit(wdat, ACQ_EN_POS);
  wire         w_low_power_direct_bit       = field_bit(wdat, LP_DIRECT_POS);
  wire         w_direct     = field_bit(wdat, DIRECT_EN_POS);
  wire         w_capture    = field_bit(wdat, CAPTURE_POS);
  wire         w_parity     = field_bit(wdat, PARITY_POS);
  wire [1:0]   w_chan       = wdat[CHAN_HI_POS:CHAN_LO_POS];

  // Interface state.
  wire         iface_idle   = ~sen_q & ~direct_q & ~low_power_direct_bit_q;
  wire         sen_start    = wr_status & w_sen & iface_idle;
  wire         auto_done    = (auto_q == AUTO_CONV) & adc_done;
  wire         settle_end   = (settle_q == AUTO_SETTLE_CYCLES - CNT_STEP);

  // The low-power bit blocks direct enable except right after it was raised.
  wire         direct_ok    = ~sen_q & (~low_power_direct_bit_q | lp_entry_q);
  wire         lp_arm       = wr_status & w_low_power_direct_bit & ~low_power_direct_bit_q;
  wire         low_power_direct_bit_fall    = wr_status & ~w_low_power_direct_bit & low_power_direct_bit_q;

  // Capture writes count only in direct mode and never during auto mode.
  wire         cap_wr1      = wr_mode & w_capture & direct_q & ~sen_q;
  wire         full_direct  = direct_q & ~low_power_direct_bit_q;
  wire         direct_trig  = cap_wr1 & ~low_power_direct_bit_q & ~capture_q;
  wire         direct_clr   = full_direct & capture_q & adc_done;
  wire         capture_clr  = direct_clr | low_power_direct_bit_fall;
  wire         lp_run       = direct_q & low_power_direct_bit_q & capture_q;

  // A pacer trigger that lands after the mode was left is dropped.
  wire         lp_trig_ok   = lp_trig & lp_run;

  wire [7:0]   status_rd    = pack_status(sen_q, low_power_direct_bit_q);
  wire [7:0]   mode_rd      = pack_mode(direct_q, capture_q, chan_q, parity_q);
  wire [7:0]   rd_byte      = read_select(hit_status, hit_mode, status_rd, mode_rd);

  // Acquisition enable is set by software and cleared by the end of the cycle.
  assign sen_d      = set_clear(sen_start, auto_done, sen_q);
  assign low_power_direct_bit_d     = wr_status ? w_low_power_direct_bit : low_power_direct_bit_q;
  assign lp_entry_d = set_clear(lp_arm, wr_mode | low_power_direct_bit_fall, lp_entry_q);
  assign direct_d   = wr_mode ? (w_direct & (direct_q | direct_ok)) : direct_q;
  assign capture_d  = set_clear(cap_wr1, capture_clr, capture_q);
  assign chan_d     = wr_mode ? w_chan : chan_q;

  // A fault arriving with a clearing write is kept.
  assign parity_d   = set_clear(parity_error, wr_mode & w_parity, parity_q);
  assign trig_d     = auto_trig | direct_trig | lp_trig_ok;

  // Automatic acquisition: settle the front end, trigger once, wait for the result.
  always_comb begin
    auto_d    = auto_q;
    settle_d  = settle_q;
    auto_trig = 1'b0;
    case (auto_q)
      AUTO_IDLE: begin
        settle_d = CNT_ZERO;
        if (sen_start) begin
          auto_d = AUTO_SETTLE;
        end
      end
      AUTO_SETTLE: begin
        settle_d = settle_q + CNT_STEP;
        if (settle_end) begin
          auto_d    = AUTO_CONV;
          auto_trig = 1'b1;
        end
      end
      AUTO_CONV: begin
        settle_d = CNT_ZERO;
        if (adc_done) begin
          auto_d = AUTO_IDLE;
        end
      end
      default: begin
        auto_d   = AUTO_IDLE;
        settle_d = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= AUTO_IDLE;
    end else begin
      auto_q <= auto_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= CNT_ZERO;
    end else begin
      settle_q <= settle_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= STATUS_CTRL_RESET[ACQ_EN_POS];
    end else begin
      sen_q <= sen_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_direct_bit_q <= STATUS_CTRL_RESET[LP_DIRECT_POS];
    end else begin
      low_power_direct_bit_q <= low_power_direct_bit_d;
    end
  end

  // The entry window opens when the low-power bit rises; the next mode write closes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_entry_q <= 1'b0;
    end else begin
      lp_entry_q <= lp_entry_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_q <= MODE_CTRL_RESET[DIRECT_EN_POS];
    end else begin
      direct_q <= direct_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= MODE_CTRL_RESET[CAPTURE_POS];
    end else begin
      capture_q <= capture_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= MODE_CTRL_RESET[CHAN_HI_POS:CHAN_LO_POS];
    end else begin
      chan_q <= chan_d;
    end
  end

  // The parity flag is kept until software clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_q <= MODE_CTRL_RESET[PARITY_POS];
    end else begin
      parity_q <= parity_d;
    end
  end

  // The converter is powered while an automatic or direct measurement is underway.
  // It also stays on with every trigger, so no conversion starts unpowered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2v_q <= 1'b0;
    end else begin
      c2v_q <= sen_d | direct_d | trig_d;
    end
  end

  // The converter trigger leaves on a flop, one clock after its source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  // Read data is captured in the setup cycle and stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  lp_trigger_fsm u_lp_trigger (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (lp_run),
    .adc_done (adc_done),
    .trig     (lp_trig)
  );

  assign prdata      = prdata_q;
  // Zero wait states; only an unmapped address is refused.
  assign pready      = 1'b1;
  assign pslverr     = access_phase & ~mapped;
  assign c2v_power   = c2v_q;
  assign chan_select = chan_q;
  assign adc_trigger = trig_q;

endmodule // sensor_meas_control

// file: testbench/meas_ctrl_checker.sv
// Port-level assertions of the sensor measurement control block.
module meas_ctrl_checker
  import meas_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        c2v_power,
  input wire logic [1:0]  chan_select,
  input wire logic        adc_trigger,
  input wire logic        adc_done,
  input wire logic        parity_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] chan_q;
  wire        acc     = psel && penable;
  wire        hit     = paddr == STATUS_CTRL_ADDR || paddr == MODE_CTRL_ADDR;
  wire        wr_mode = acc && pwrite && pstrb[0] && paddr == MODE_CTRL_ADDR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chan_q <= 2'h0;
    else if (wr_mode) chan_q <= pwdata[5:4];
  end
  a_unmapped_err: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && hit |-> pready && !pslverr)
    else $error("mapped access refused");
  a_status_spare: assert property (acc && !pwrite && paddr == STATUS_CTRL_ADDR
    |-> prdata[31:5] == 27'h0 && prdata[2:0] == 3'h0)
    else $error("status spare bits set");
  a_mode_resv: assert property (acc && !pwrite && paddr == MODE_CTRL_ADDR
    |-> prdata[31:8] == 24'h0 && prdata[2:0] == 3'h0)
    else $error("mode reserved bits set");
  a_trig_pulse: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger longer than one cycle");
  a_trig_power: assert property (adc_trigger |-> c2v_power)
    else $error("trigger without converter power");
  a_chan_follow: assert property (wr_mode |=> ##[0:1] chan_select == chan_q)
    else $error("channel select not updated");
  a_reset_idle: assert property ($rose(presetn) |-> !c2v_power && !adc_trigger && chan_select == 2'h0)
    else $error("outputs not idle after reset");
endmodule // meas_ctrl_checker

bind sensor_meas_control meas_ctrl_checker meas_ctrl_checker_inst (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .c2v_power(c2v_power), .chan_select(chan_select),
  .adc_trigger(adc_trigger), .adc_done(adc_done), .parity_error(parity_error));

// file: testbench/adc_model.sv
// Converter stand-in that answers each trigger with an end-of-conversion pulse.
module adc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic adc_trigger,
  output logic      adc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pipe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pipe_q <= 4'h0;
    else pipe_q <= {pipe_q[2:0], adc_trigger};
  end
  // Slow answers come four cycles after the trigger, prompt ones after one.
  assign adc_done = slow ? pipe_q[3] : pipe_q[0];
endmodule // adc_model

// file: testbench/sensor_meas_control_test.sv
// Register-level test sequence for the sensor measurement control block.
module sensor_meas_control_test import meas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        slow = 1'b0, parity_error = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, c2v_power, adc_trigger, adc_done, er;
  logic [1:0]  chan_select;
  int          bad_count = 0, n_compared = 0, trig_n = 0, t;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (adc_trigger === 1'b1) trig_n++;
  sensor_meas_control sensor_meas_control_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .c2v_power(c2v_power), .chan_select(chan_select), .adc_trigger(adc_trigger),
    .adc_done(adc_done), .parity_error(parity_error));
  adc_model adc_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .adc_trigger(adc_trigger),
    .adc_done(adc_done));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      bad_count++;
      results();
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(name, exp, rd);
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    int i;
    i = 0;
    do begin
      xfer(1'b0, a, 8'h00);
      i++;
    end while ((rd[7:0] & m) != 8'h00 && i < 100);
    if (i >= 100) begin
      bad_count++;
      results();
    end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", STATUS_CTRL_ADDR, 32'h0);
    rdc("mode", MODE_CTRL_ADDR, 32'h0);
    xfer(1'b0, 8'h08, 8'h00);
    chk("slverr", 32'h1, {31'h0, er});
    t = trig_n;
    xfer(1'b1, STATUS_CTRL_ADDR, 8'h10);
    rdc("acq_busy", STATUS_CTRL_ADDR, 32'h10);
    chk("power", 32'h1, {31'h0, c2v_power});
    xfer(1'b1, MODE_CTRL_ADDR, 8'hc0);
    rdc("auto_block", MODE_CTRL_ADDR, 32'h0);
    poll(STATUS_CTRL_ADDR, 8'h10);
    chk("auto_trig", 32'h1, trig_n - t);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h80);
    rdc("direct_on", MODE_CTRL_ADDR, 32'h80);
    chk("no_trig", 32'h1, trig_n - t);
    xfer(1'b1, MODE_CTRL_ADDR, 8'hc0);
    poll(MODE_CTRL_ADDR, 8'h40);
    chk("one_trig", 32'h2, trig_n - t);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h00);
    rdc("direct_off", MODE_CTRL_ADDR, 32'h0);
    chk("power_off", 32'h0, {31'h0, c2v_power});
    xfer(1'b1, STATUS_CTRL_ADDR, 8'h08);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h10);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h90);
    rdc("lp_block", MODE_CTRL_ADDR, 32'h10);
    xfer(1'b1, STATUS_CTRL_ADDR, 8'h00);
    slow <= 1'b1;
    xfer(1'b1, STATUS_CTRL_ADDR, 8'h08);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h80);
    xfer(1'b1, MODE_CTRL_ADDR, 8'hc0);
    t = trig_n;
    repeat (160) @(posedge pclk);
    chk("lp_trig", 32'h2, trig_n - t);
    rdc("lp_hold", MODE_CTRL_ADDR, 32'hc0);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h00);
    xfer(1'b1, STATUS_CTRL_ADDR, 8'h00);
    rdc("lp_exit", MODE_CTRL_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, MODE_CTRL_ADDR, 8'(i << 4));
      rdc("chan_rd", MODE_CTRL_ADDR, 32'(i << 4));
      chk("chan", 32'(i), {30'h0, chan_select});
    end
    parity_error <= 1'b1;
    @(posedge pclk);
    parity_error <= 1'b0;
    rdc("parity", MODE_CTRL_ADDR, 32'h38);
    xfer(1'b1, MODE_CTRL_ADDR, 8'h0f);
    rdc("resv", MODE_CTRL_ADDR, 32'h0);
    results();
  end
endmodule // sensor_meas_control_test
